/* logic/can_acceptance_mask_filter.sv */
`timescale 1ns/1ps
`include "can_mask_params.svh"
// Overview of operation
// - extended global mask one bit forces equality, zero bit accepts either level
// - extended global mask used only for extended frames and extended-format objects
// - reset leaves extended mask bytes; its reserved low bits read zero
// - extended mask bytes hold id 28-21, 20-13, 12-5, then 4-0 in bits 7-3
// - remote frames filtered by global masks; reply uses object's own stored identifier
// - every frame checked; match against an active object is stored
// - last-object local mask one bit forces equality, zero bit is don't-care
// - object 15 considered only after objects 1 to 14 all miss
// - object 15 effective mask is local mask ANDed with global mask
// - direction mask one forces direction match, zero accepts data and remote
// - format mask one forces format match, zero accepts both identifier formats
// - extended access flag low: direction/format bits read 00, act as 11
// - reset leaves local mask bytes; reserved bit zero of last byte reads zero
// - last local byte: id 4-0 in 7-3, direction bit 2, format bit 1
// - object 15 is receive-only, may take both formats and types
// - standard mask only for standard frames/objects, eleven bits cover id 28-18
module can_acceptance_mask_filter #(
    parameter int NUM_OBJ = `NUM_OBJECTS
) (
    input  wire logic                       i_ref_clk,       // system clock
    input  wire logic                       i_rst_n,         // sync reset, active low
    input  wire logic                       i_reg_wr,        // register write strobe
    input  wire logic                       i_reg_rd,        // register read strobe
    input  wire logic [7:0]                 i_reg_addr,      // register byte offset
    input  wire logic [7:0]                 i_reg_wdata,     // write data
    input  wire logic                       i_extended_access_flag, // control register flag
    input  wire can_mask_pkg::frame_hdr_t   i_frame,         // incoming frame header
    input  wire can_mask_pkg::obj_arb_t [NUM_OBJ-1:0] i_obj, // arbitration of objects 1..15
    output logic [7:0]                      o_reg_rdata,     // read data
    output logic                            o_reg_rvalid,    // read data valid
    output logic                            o_match,         // frame accepted pulse
    output logic [3:0]                      o_match_obj,     // accepting object number 1..15
    output logic [28:0]                     o_reply_id,      // stored id of accepting object
    output logic                            o_reply_req      // remote frame answer request
);

    ////////////////////////////////////////////////////////////////////////////
    // mask registers: no reset, contents survive hardware reset
    logic [7:0]  std_mask [2];
    logic [31:0] ext_mask;
    logic [31:0] last_mask;
    logic [7:0]  next_std_mask [2];
    logic [31:0] next_ext_mask;
    logic [31:0] next_last_mask;

    always_comb begin
        next_std_mask[0] = std_mask[0];
        next_std_mask[1] = std_mask[1];
        next_ext_mask    = ext_mask;
        next_last_mask   = last_mask;
        if (i_reg_wr) begin
            case (i_reg_addr)
                `OFS_STD_MASK_BYTE0:  next_std_mask[0]       = i_reg_wdata;
                `OFS_STD_MASK_BYTE1:  next_std_mask[1]       = i_reg_wdata & `STD_BYTE1_RW_MASK;
                `OFS_EXT_MASK_BYTE0:  next_ext_mask[31:24]   = i_reg_wdata;
                `OFS_EXT_MASK_BYTE1:  next_ext_mask[23:16]   = i_reg_wdata;
                `OFS_EXT_MASK_BYTE2:  next_ext_mask[15:8]    = i_reg_wdata;
                `OFS_EXT_MASK_BYTE3:  next_ext_mask[7:0]     = i_reg_wdata & `EXT_BYTE3_RW_MASK;
                `OFS_LAST_MASK_BYTE0: next_last_mask[31:24]  = i_reg_wdata;
                `OFS_LAST_MASK_BYTE1: next_last_mask[23:16]  = i_reg_wdata;
                `OFS_LAST_MASK_BYTE2: next_last_mask[15:8]   = i_reg_wdata;
                `OFS_LAST_MASK_BYTE3: begin
                    // direction/format bits only take writes while extended access is open
                    next_last_mask[7:3] = i_reg_wdata[7:3];
                    next_last_mask[0]   = 1'b0;
                    if (i_extended_access_flag) begin
                        next_last_mask[2:1] = i_reg_wdata[2:1];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        std_mask[0] <= next_std_mask[0];
        std_mask[1] <= next_std_mask[1];
        ext_mask    <= next_ext_mask;
        last_mask   <= next_last_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    logic [7:0] rd_mux;
    logic [7:0] next_rdata;
    logic       next_rvalid;

    always_comb begin
        case (i_reg_addr)
            `OFS_STD_MASK_BYTE0:  rd_mux = std_mask[0];
            `OFS_STD_MASK_BYTE1:  rd_mux = std_mask[1] | `STD_BYTE1_RES_ONES;
            `OFS_EXT_MASK_BYTE0:  rd_mux = ext_mask[31:24];
            `OFS_EXT_MASK_BYTE1:  rd_mux = ext_mask[23:16];
            `OFS_EXT_MASK_BYTE2:  rd_mux = ext_mask[15:8];
            `OFS_EXT_MASK_BYTE3:  rd_mux = ext_mask[7:0] & `EXT_BYTE3_RW_MASK;
            `OFS_LAST_MASK_BYTE0: rd_mux = last_mask[31:24];
            `OFS_LAST_MASK_BYTE1: rd_mux = last_mask[23:16];
            `OFS_LAST_MASK_BYTE2: rd_mux = last_mask[15:8];
            `OFS_LAST_MASK_BYTE3: rd_mux = i_extended_access_flag ?
                                           (last_mask[7:0] & 8'hFE) :
                                           (last_mask[7:0] & `LAST_BYTE3_ID_MASK);
            default:              rd_mux = 8'h00;
        endcase
        next_rdata  = i_reg_rd ? rd_mux : o_reg_rdata;
        next_rvalid = i_reg_rd;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rdata  <= next_rdata;
            o_reg_rvalid <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // match comparators, one per object
    logic [28:0] std_glob;
    logic [28:0] ext_glob;
    logic [28:0] local_id_mask;
    logic        eff_dir_mask;
    logic        eff_fmt_mask;
    logic [NUM_OBJ-1:0] hit;

    // standard mask covers only id 28..18; lower positions are don't-care
    assign std_glob      = {std_mask[0], std_mask[1][7:5], 18'h00000};
    assign ext_glob      = ext_mask[31:3];
    assign local_id_mask = last_mask[31:3];
    // with extended access closed the hidden bits behave as must-match
    assign eff_dir_mask  = i_extended_access_flag ? last_mask[`LAST_DIR_BIT] : 1'b1;
    assign eff_fmt_mask  = i_extended_access_flag ? last_mask[`LAST_FMT_BIT] : 1'b1;

    genvar g;
    generate
        for (g = 0; g < NUM_OBJ; g++) begin : gen_cmp
            logic [28:0] glob;
            logic [28:0] eff;
            logic        id_ok;
            // pick the global mask by format; the frame's format selects the mask
            assign glob  = i_frame.ext_fmt ? ext_glob : std_glob;
            if (g == NUM_OBJ - 1) begin : gen_last
                assign eff   = glob & local_id_mask;
                assign id_ok = ~|(eff & (i_frame.id ^ i_obj[g].id));
                // receive only: a hit here never raises a reply, the priority stage drops it
                assign hit[g] = i_frame.valid & i_obj[g].active & id_ok
                              & (~eff_dir_mask | (i_frame.remote == i_obj[g].dir))
                              & (~eff_fmt_mask | (i_frame.ext_fmt == i_obj[g].ext_fmt));
            end else begin : gen_low
                assign eff   = glob;
                assign id_ok = ~|(eff & (i_frame.id ^ i_obj[g].id));
                assign hit[g] = i_frame.valid & i_obj[g].active & id_ok
                              & (i_frame.ext_fmt == i_obj[g].ext_fmt);
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // priority: lowest object first, object 15 last
    logic [3:0]  sel_num;
    logic        sel_any;
    logic        next_match;
    logic [3:0]  next_match_obj;
    logic [28:0] next_reply_id;
    logic        next_reply_req;

    always_comb begin
        sel_any = 1'b0;
        sel_num = 4'h0;
        for (int k = NUM_OBJ - 2; k >= 0; k--) begin
            if (hit[k]) begin
                sel_any = 1'b1;
                sel_num = 4'(k + 1);
            end
        end
        if (!sel_any && hit[NUM_OBJ-1]) begin
            sel_any = 1'b1;
            sel_num = 4'(NUM_OBJ);
        end
        next_match     = sel_any;
        next_match_obj = sel_any ? sel_num : 4'h0;
        next_reply_id  = sel_any ? i_obj[sel_num - 4'h1].id : 29'h00000000;
        // a remote frame that hits object 15 gets no answer: it only receives
        next_reply_req = sel_any & i_frame.remote & (sel_num != 4'(NUM_OBJ));
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_match     <= 1'b0;
            o_match_obj <= 4'h0;
            o_reply_id  <= 29'h00000000;
            o_reply_req <= 1'b0;
        end else begin
            o_match     <= next_match;
            o_match_obj <= next_match_obj;
            o_reply_id  <= next_reply_id;
            o_reply_req <= next_reply_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // a read is a request edge followed by the answer edge; the sequences name the steps
    sequence s_read_ext_byte0;
        i_reg_rd && i_reg_addr == `OFS_EXT_MASK_BYTE0;
    endsequence
    sequence s_read_ext_byte3;
        i_reg_rd && i_reg_addr == `OFS_EXT_MASK_BYTE3;
    endsequence
    sequence s_read_last_byte3;
        i_reg_rd && i_reg_addr == `OFS_LAST_MASK_BYTE3;
    endsequence
    sequence s_read_answer;
        o_reg_rvalid;
    endsequence
    sequence s_remote_low_hit;
        i_frame.valid && i_frame.remote && (|hit[NUM_OBJ-2:0]);
    endsequence
    sequence s_reply_raised;
        o_match && o_reply_req;
    endsequence

    AST_EXT_RES_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_reg_rd && i_reg_addr == `OFS_EXT_MASK_BYTE3 |=> o_reg_rdata[2:0] == 3'h0)
        else $error("extended mask reserved bits not zero");
    AST_LAST_RES_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_reg_rd && i_reg_addr == `OFS_LAST_MASK_BYTE3 |=> o_reg_rdata[0] == 1'b0)
        else $error("local mask reserved bit not zero");
    AST_EAF_HIDE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_reg_rd && i_reg_addr == `OFS_LAST_MASK_BYTE3 && !i_extended_access_flag
        |=> o_reg_rdata[2:1] == 2'b00)
        else $error("direction/format bits visible while access closed");
    AST_LOWEST_WINS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        hit[0] |=> o_match && o_match_obj == 4'h1)
        else $error("lowest matching object not chosen");
    AST_LAST_AFTER: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (|hit[NUM_OBJ-2:0]) |=> o_match_obj != 4'(NUM_OBJ))
        else $error("object 15 took a frame another object matched");
    AST_NO_HIT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !(|hit) |=> !o_match && o_match_obj == 4'h0)
        else $error("match reported without any hit");
    AST_REPLY_ID: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_reply_req && o_match_obj == 4'h3 |-> o_reply_id == $past(i_obj[2].id))
        else $error("reply does not carry stored identifier");
    AST_RECV_ONLY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_match_obj == 4'(NUM_OBJ) |-> !o_reply_req)
        else $error("object 15 answered a remote frame");
    // only reset entry is watched: the masks are unknown until the host first loads them
    AST_MASK_KEEP: assert property (@(posedge i_ref_clk)
        !i_rst_n && $past(i_rst_n) == 1'b1 && !i_reg_wr |=> ext_mask == $past(ext_mask))
        else $error("extended mask changed across reset");
    AST_LOCAL_KEEP: assert property (@(posedge i_ref_clk)
        !i_rst_n && $past(i_rst_n) == 1'b1 && !i_reg_wr |=> last_mask == $past(last_mask))
        else $error("local mask changed across reset");
    AST_EXT_MAP_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_read_ext_byte0 |=> s_read_answer ##0 o_reg_rdata == $past(ext_glob[28:21]))
        else $error("first extended mask byte does not hold id 28-21");
    AST_EXT_MAP_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_read_ext_byte3 |=> s_read_answer ##0 o_reg_rdata == {$past(ext_glob[4:0]), 3'h0})
        else $error("last extended mask byte does not hold id 4-0");
    AST_LOCAL_MAP_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_read_last_byte3 |=> s_read_answer ##0 o_reg_rdata[7:3] == $past(local_id_mask[4:0]))
        else $error("last local mask byte does not hold id 4-0");
    AST_REPLY_RAISE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_remote_low_hit |=> s_reply_raised)
        else $error("remote frame on a low object raised no reply");
    // object 3 stands in for the low objects: every low comparator is the same generate body
    AST_EXT_MUST_MATCH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && i_frame.ext_fmt && i_obj[2].active && i_obj[2].ext_fmt
        && ((i_frame.id ^ i_obj[2].id) & ext_mask[31:3]) == 29'h00000000
        |=> o_match && o_match_obj != 4'h0 && o_match_obj <= 4'h3)
        else $error("extended frame equal under global mask was refused");
    AST_STD_MUST_MATCH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && !i_frame.ext_fmt && i_obj[2].active && !i_obj[2].ext_fmt
        && ((i_frame.id[28:18] ^ i_obj[2].id[28:18]) & {std_mask[0], std_mask[1][7:5]}) == 11'h000
        |=> o_match && o_match_obj != 4'h0 && o_match_obj <= 4'h3)
        else $error("standard frame equal under standard mask was refused");
    AST_FMT_GATE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && i_frame.ext_fmt != i_obj[2].ext_fmt |=> o_match_obj != 4'h3)
        else $error("low object took a frame of the other format");
    AST_INACTIVE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && !i_obj[2].active |=> o_match_obj != 4'h3)
        else $error("inactive object took a frame");
    AST_HIDDEN_MUST: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && !i_extended_access_flag
        && (i_frame.remote != i_obj[NUM_OBJ-1].dir || i_frame.ext_fmt != i_obj[NUM_OBJ-1].ext_fmt)
        |=> o_match_obj != 4'(NUM_OBJ))
        else $error("hidden direction/format bits did not act as must-match");
    AST_DIR_MUST: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && i_extended_access_flag && last_mask[`LAST_DIR_BIT]
        && i_frame.remote != i_obj[NUM_OBJ-1].dir |=> o_match_obj != 4'(NUM_OBJ))
        else $error("direction mismatch accepted by last object");
    AST_FMT_MUST: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && i_extended_access_flag && last_mask[`LAST_FMT_BIT]
        && i_frame.ext_fmt != i_obj[NUM_OBJ-1].ext_fmt |=> o_match_obj != 4'(NUM_OBJ))
        else $error("format mismatch accepted by last object");
    AST_LAST_EXACT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && i_obj[NUM_OBJ-1].active && i_frame.id == i_obj[NUM_OBJ-1].id
        && i_frame.remote == i_obj[NUM_OBJ-1].dir && i_frame.ext_fmt == i_obj[NUM_OBJ-1].ext_fmt
        && !(|hit[NUM_OBJ-2:0]) |=> o_match_obj == 4'(NUM_OBJ))
        else $error("exact frame refused by last object");
    AST_GLOBAL_DONT_CARE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_frame.valid && i_frame.ext_fmt && i_obj[NUM_OBJ-1].active && i_obj[NUM_OBJ-1].ext_fmt
        && i_frame.remote == i_obj[NUM_OBJ-1].dir && !(|hit[NUM_OBJ-2:0])
        && ((i_frame.id ^ i_obj[NUM_OBJ-1].id) & ext_mask[31:3]) == 29'h00000000
        |=> o_match_obj == 4'(NUM_OBJ))
        else $error("global don't-care position was checked by last object");
    AST_WR_HIDDEN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_reg_wr && i_reg_addr == `OFS_LAST_MASK_BYTE3 && !i_extended_access_flag
        |=> last_mask[2:1] == $past(last_mask[2:1]))
        else $error("direction/format bits written while access closed");

endmodule

/* pkg/can_mask_params.svh */
`ifndef CAN_MASK_PARAMS_SVH
`define CAN_MASK_PARAMS_SVH

// register byte offsets on the cpu register port
`define OFS_STD_MASK_BYTE0      8'h06
`define OFS_STD_MASK_BYTE1      8'h07
`define OFS_EXT_MASK_BYTE0      8'h08
`define OFS_EXT_MASK_BYTE1      8'h09
`define OFS_EXT_MASK_BYTE2      8'h0A
`define OFS_EXT_MASK_BYTE3      8'h0B
`define OFS_LAST_MASK_BYTE0     8'h0C
`define OFS_LAST_MASK_BYTE1     8'h0D
`define OFS_LAST_MASK_BYTE2     8'h0E
`define OFS_LAST_MASK_BYTE3     8'h0F
// field layout of the last byte of each mask
`define EXT_BYTE3_RW_MASK       8'hF8
`define STD_BYTE1_RW_MASK       8'hE0
`define STD_BYTE1_RES_ONES      8'h1F
`define LAST_BYTE3_ID_MASK      8'hF8
`define LAST_DIR_BIT            2
`define LAST_FMT_BIT            1
// identifier layout
`define ID_WIDTH                29
`define STD_ID_LSB              18
`define NUM_OBJECTS             15

`endif

/* pkg/can_mask_pkg.sv */
package can_mask_pkg;

    // one arbitration entry of a message object
    typedef struct packed {
        logic        active;
        logic        ext_fmt;
        logic        dir;
        logic [28:0] id;
    } obj_arb_t;

    // one incoming frame header
    typedef struct packed {
        logic        valid;
        logic        ext_fmt;
        logic        remote;
        logic [28:0] id;
    } frame_hdr_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOW   = 2'b01,
        ST_LAST  = 2'b10
    } match_state_t;

endpackage

/* tb/can_node_model.sv */
`timescale 1ns/1ps
// far-side node: puts one frame header on the receive path for one cycle
module can_node_model (
    input  wire logic                i_ref_clk, // system clock
    output can_mask_pkg::frame_hdr_t o_frame    // header seen by the filter
);
    initial o_frame = '0;
    // between frames the header lines show the inverse, so a stale id never matches by chance
    task automatic send(input can_mask_pkg::frame_hdr_t h);
        @(negedge i_ref_clk);
        o_frame <= h;
        @(negedge i_ref_clk);
        o_frame <= {1'b0, ~h[30:0]};
    endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic                                  clk;
    logic                                  rst_n;
    logic                                  wr;
    logic                                  rd;
    logic                                  flag;
    logic                            [7:0] addr;
    logic                            [7:0] wdata;
    logic                            [7:0] rdata;
    logic                                  rvalid;
    logic                                  match;
    logic                            [3:0] mobj;
    logic                           [28:0] rid;
    logic                                  rreq;
    can_mask_pkg::frame_hdr_t              frame;
    can_mask_pkg::obj_arb_t         [14:0] obj;
    int                                    n_mismatch = 0;
    int                                    checked = 0;
    localparam logic [28:0] X = 29'h0ABC1234;
    localparam logic [28:0] Y = 29'h1555AAAA;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    can_node_model node (.i_ref_clk(clk), .o_frame(frame));
    can_acceptance_mask_filter DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_extended_access_flag(flag), .i_frame(frame),
        .i_obj(obj), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_match(match),
        .o_match_obj(mobj), .o_reply_id(rid), .o_reply_req(rreq));

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic fail(input string m);
        n_mismatch++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) fail("register read");
    endtask

    task automatic cmp_match(input logic [3:0] eo, input logic q, input logic [28:0] eid);
        checked++;
        if (match !== (eo != 4'h0) || mobj !== eo || rreq !== q || rid !== eid) fail("acceptance");
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(negedge clk);
        wr <= 1'b0;
    endtask

    // read data stands from the rising edge that samples the strobe, so it is judged at the next falling edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        rd <= 1'b1;
        addr <= a;
        @(negedge clk);
        rd <= 1'b0;
        cmp8({7'h00, rvalid}, 8'h01);
        cmp8(rdata, e);
    endtask

    task automatic frm(input logic e, input logic r, input logic [28:0] id,
                       input logic [3:0] eo, input logic q, input logic [28:0] eid);
        node.send({1'b1, e, r, id});
        cmp_match(eo, q, eid);
    endtask

    task automatic t_regs();
        logic [7:0] d [8] = '{8'hA5, 8'h5A, 8'hC3, 8'hFF, 8'h3C, 8'h96, 8'h69, 8'hFF};
        for (int i = 0; i < 8; i++) wr_reg(8'h08 + i[7:0], d[i]);
        wr_reg(8'h06, 8'hFF);
        wr_reg(8'h07, 8'hFF);
        @(negedge clk) rst_n <= 1'b0;
        repeat (2) @(negedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h08, 8'hA5);
        rd_chk(8'h0B, 8'hF8);
        rd_chk(8'h0E, 8'h69);
        rd_chk(8'h0F, 8'hFE);
        rd_chk(8'h07, 8'hFF);
        flag <= 1'b0;
        rd_chk(8'h0F, 8'hF8);
        rd_chk(8'h10, 8'h00);
        wr_reg(8'h0F, 8'hF8);
        flag <= 1'b1;
        rd_chk(8'h0F, 8'hFE);
    endtask

    task automatic t_global();
        wr_reg(8'h08, 8'hFF);
        wr_reg(8'h09, 8'hFF);
        wr_reg(8'h0A, 8'hFF);
        wr_reg(8'h0B, 8'hF0);
        obj = '0;
        obj[2] = {3'b110, X};
        obj[4] = {3'b110, X};
        frm(1'b1, 1'b0, X, 4'h3, 1'b0, X);
        frm(1'b1, 1'b0, X ^ 29'h1, 4'h3, 1'b0, X);
        frm(1'b1, 1'b1, X ^ 29'h1, 4'h3, 1'b1, X);
        frm(1'b1, 1'b0, X ^ 29'h20, 4'h0, 1'b0, 29'h0);
        frm(1'b0, 1'b0, X, 4'h0, 1'b0, 29'h0);
        obj[2].active = 1'b0;
        frm(1'b1, 1'b0, X, 4'h5, 1'b0, X);
        obj[0] = {3'b110, X};
        frm(1'b1, 1'b0, X, 4'h1, 1'b0, X);
        obj[0] = '0;
    endtask

    task automatic t_std();
        wr_reg(8'h07, 8'hE0);
        obj[2] = {3'b100, X};
        frm(1'b0, 1'b0, X ^ 29'h20000, 4'h3, 1'b0, X);
        frm(1'b0, 1'b0, X ^ 29'h40000, 4'h0, 1'b0, 29'h0);
    endtask

    task automatic t_last();
        obj[2] = {3'b110, X};
        obj[4] = '0;
        obj[14] = {3'b110, Y};
        wr_reg(8'h0F, 8'hF8);
        frm(1'b1, 1'b1, Y, 4'hF, 1'b0, Y);
        frm(1'b0, 1'b0, Y, 4'hF, 1'b0, Y);
        frm(1'b1, 1'b0, Y ^ 29'h1, 4'hF, 1'b0, Y);
        flag <= 1'b0;
        frm(1'b1, 1'b1, Y, 4'h0, 1'b0, 29'h0);
        frm(1'b1, 1'b0, Y, 4'hF, 1'b0, Y);
        flag <= 1'b1;
        wr_reg(8'h0F, 8'hFC);
        frm(1'b1, 1'b1, Y, 4'h0, 1'b0, 29'h0);
        wr_reg(8'h0F, 8'hFA);
        frm(1'b0, 1'b0, Y, 4'h0, 1'b0, 29'h0);
        wr_reg(8'h0F, 8'hF8);
        wr_reg(8'h0C, 8'h7F);
        frm(1'b1, 1'b0, Y ^ 29'h10000000, 4'hF, 1'b0, Y);
        for (int i = 0; i < 4; i++) wr_reg(8'h0C + i[7:0], 8'h00);
        frm(1'b1, 1'b0, X, 4'h3, 1'b0, X);
        frm(1'b1, 1'b0, Y ^ 29'hFFF, 4'hF, 1'b0, Y);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        flag = 1'b1;
        obj = '0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_global();
        t_std();
        t_last();
        tally_and_finish();
    end
endmodule
